// ===== freq_hop_channel_switch.sv
// Channel switch and retune control reached over the serial register port.
// What this block does
// - Unlock may fire during switch; masking optional.
// - Transmit preamble length programmable, up to 255.
// - Last byte readable only after packet end.
// - Ramp timing adjustable through three registers.
// - Unlock in receive keeps receive, raises flag.
`timescale 1ns/1ps
module freq_hop_channel_switch
   import fhop_pkg::*;
#(
   parameter int LOCK_CYCLES_P = LOCK_CYCLES
) (
   // Clock and reset
   input  wire logic         clock_i,
   input  wire logic         rstn_i,
   // Serial register port
   input  wire logic         sclk_i,
   input  wire logic         csn_i,
   input  wire logic         sdi_i,
   output logic              sdo_o,
   output logic              sdo_oen_o,
   // Synthesizer
   input  wire logic         pll_unlock_i,
   input  wire logic         unlock_clear_i,
   output logic              unlock_irq_o,
   output logic              retune_busy_o,
   output chan_freq_t        chan_freq_o,
   // Modem
   input  wire logic         rx_byte_valid_i,
   input  wire logic [7:0]   rx_byte_i,
   input  wire logic         rx_last_i,
   input  wire logic         rx_packet_done_i,
   output logic              packet_end_indicator_o,
   output radio_state_t      radio_state_o,
   output logic [7:0]        tx_preamble_length_o,
   output ramp_cfg_t         ramp_cfg_o
);

   logic [2:0]   sclk_sync;
   logic [1:0]   csn_sync;
   logic [1:0]   sdi_sync;
   logic [2:0]   unlock_sync;
   logic         sclk_rise;
   logic         sclk_fall;
   logic         unlock_rise;
   logic [3:0]   bit_cnt_reg;
   logic [7:0]   rx_sh_reg;
   logic [7:0]   tx_sh_reg;
   logic [6:0]   addr_reg;
   logic         wr_reg;
   logic         wr_pulse_reg;
   logic [6:0]   wr_addr_reg;
   logic [7:0]   wr_data_reg;
   logic [7:0]   irq_enable_group4_reg;
   logic [3:0]   radio_state_cmd_reg;
   logic         unlock_status_reg;
   logic [$clog2(LOCK_CYCLES_P+1)-1:0] lock_cnt_reg;
   logic [7:0]   fifo_byte_reg;
   logic         fifo_last_reg;
   logic         state_cmd_wr;
   logic         freq_wr;

   function automatic logic [3:0] state_code(input radio_state_t s);
      unique case (s)
         RADIO_OFF: state_code = CMD_OFF;
         RADIO_RX:  state_code = CMD_RX_ON;
         RADIO_TX:  state_code = CMD_TX_ON;
         default:   state_code = CMD_OFF;
      endcase
   endfunction : state_code

   // The last byte of a packet reads as blank until the packet end is flagged, so a too early read cannot
   // pick up a byte whose check has not finished.
   function automatic logic [7:0] read_mux(input logic [6:0] a);
      unique case (a)
         ADDR_IRQ_EN4:      read_mux = irq_enable_group4_reg;
         ADDR_RX_ON_ADJ:    read_mux = ramp_cfg_o.rx_on_adj;
         ADDR_TX_PRE_LEN:   read_mux = tx_preamble_length_o;
         ADDR_CH_FREQ_LOW:  read_mux = chan_freq_o.low;
         ADDR_CH_FREQ_MID:  read_mux = chan_freq_o.mid;
         ADDR_CH_FREQ_HIGH: read_mux = chan_freq_o.high;
         ADDR_TX_OFF_ADJ:   read_mux = ramp_cfg_o.tx_off_adj;
         ADDR_RADIO_STATE:  read_mux = {state_code(radio_state_o), radio_state_cmd_reg};
         ADDR_DIV_GAIN:     read_mux = ramp_cfg_o.gain;
         ADDR_RX_FIFO:      read_mux = (fifo_last_reg && !packet_end_indicator_o) ? FIFO_BLANK
                                                                                    : fifo_byte_reg;
         default:           read_mux = RESET_BYTE;
      endcase
   endfunction : read_mux

   // Pin inputs pass two flip-flops; edge detection looks only at the second and third stages.
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         sclk_sync   <= '0;
         csn_sync    <= 2'b11;
         sdi_sync    <= '0;
         unlock_sync <= '0;
      end else begin
         sclk_sync   <= {sclk_sync[1:0], sclk_i};
         csn_sync    <= {csn_sync[0], csn_i};
         sdi_sync    <= {sdi_sync[0], sdi_i};
         unlock_sync <= {unlock_sync[1:0], pll_unlock_i};
      end
   end

   assign sclk_rise    = sclk_sync[1] && !sclk_sync[2];
   assign sclk_fall    = !sclk_sync[1] && sclk_sync[2];
   assign unlock_rise  = unlock_sync[1] && !unlock_sync[2];
   assign state_cmd_wr = wr_pulse_reg && (wr_addr_reg == ADDR_RADIO_STATE);
   assign freq_wr      = wr_pulse_reg && (wr_addr_reg == ADDR_CH_FREQ_LOW || wr_addr_reg == ADDR_CH_FREQ_MID ||
                                          wr_addr_reg == ADDR_CH_FREQ_HIGH);

   // Serial frame: address byte with write flag in bit 0, then data bytes with address auto-increment.
   always_ff @(posedge clock_i) begin
      if (!rstn_i || csn_sync[1]) begin
         bit_cnt_reg  <= '0;
         rx_sh_reg    <= '0;
         tx_sh_reg    <= '0;
         addr_reg     <= '0;
         wr_reg       <= 1'b0;
         wr_pulse_reg <= 1'b0;
         wr_addr_reg  <= '0;
         wr_data_reg  <= '0;
         sdo_o        <= 1'b0;
         sdo_oen_o    <= 1'b1;
      end else begin
         wr_pulse_reg <= 1'b0;
         sdo_oen_o    <= wr_reg || (bit_cnt_reg < BIT_DATA_FIRST);
         if (sclk_rise) begin
            rx_sh_reg   <= {rx_sh_reg[6:0], sdi_sync[1]};
            bit_cnt_reg <= (bit_cnt_reg == BIT_DATA_LAST) ? BIT_DATA_FIRST : bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == BIT_ADDR_LAST) begin
               addr_reg  <= rx_sh_reg[6:0];
               wr_reg    <= sdi_sync[1];
               tx_sh_reg <= read_mux(rx_sh_reg[6:0]);
            end
            if (bit_cnt_reg == BIT_DATA_LAST) begin
               addr_reg     <= addr_reg + 7'h01;
               tx_sh_reg    <= read_mux(addr_reg + 7'h01);
               wr_pulse_reg <= wr_reg;
               wr_addr_reg  <= addr_reg;
               wr_data_reg  <= {rx_sh_reg[6:0], sdi_sync[1]};
            end
         end else if (sclk_fall && bit_cnt_reg >= BIT_DATA_FIRST && !wr_reg) begin
            sdo_o     <= tx_sh_reg[7];
            tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
         end
      end
   end

   // Plain configuration registers.
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         irq_enable_group4_reg <= RESET_BYTE;
         tx_preamble_length_o  <= RESET_BYTE;
         ramp_cfg_o            <= '0;
         chan_freq_o           <= '0;
      end else if (wr_pulse_reg) begin
         unique case (wr_addr_reg)
            ADDR_IRQ_EN4:      irq_enable_group4_reg <= wr_data_reg;
            ADDR_TX_PRE_LEN:   tx_preamble_length_o  <= wr_data_reg;
            ADDR_DIV_GAIN:     ramp_cfg_o.gain       <= wr_data_reg;
            ADDR_RX_ON_ADJ:    ramp_cfg_o.rx_on_adj  <= wr_data_reg;
            ADDR_TX_OFF_ADJ:   ramp_cfg_o.tx_off_adj <= wr_data_reg;
            ADDR_CH_FREQ_LOW:  chan_freq_o.low       <= wr_data_reg;
            ADDR_CH_FREQ_MID:  chan_freq_o.mid       <= wr_data_reg;
            ADDR_CH_FREQ_HIGH: chan_freq_o.high      <= wr_data_reg;
            default: ;
         endcase
      end
   end

   // Radio state: commands from the host; an unlock while sending forces off, while receiving it does not.
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         radio_state_o       <= RADIO_OFF;
         radio_state_cmd_reg <= CMD_OFF;
      end else if (state_cmd_wr) begin
         radio_state_cmd_reg <= wr_data_reg[STATE_CMD_LSB +: 4];
         if (wr_data_reg[STATE_CMD_LSB +: 4] == CMD_OFF) radio_state_o <= RADIO_OFF;
         else if (wr_data_reg[STATE_CMD_LSB +: 4] == CMD_RX_ON) radio_state_o <= RADIO_RX;
         else if (wr_data_reg[STATE_CMD_LSB +: 4] == CMD_TX_ON) radio_state_o <= RADIO_TX;
      end else if (unlock_rise && radio_state_o == RADIO_TX) begin
         radio_state_o <= RADIO_OFF;
      end
   end

   // Unlock flag: a new unlock beats a clear in the same cycle. Raised in every state, even mid-retune.
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         unlock_status_reg <= 1'b0;
         unlock_irq_o      <= 1'b0;
      end else begin
         if (unlock_rise) unlock_status_reg <= 1'b1;
         else if (unlock_clear_i) unlock_status_reg <= 1'b0;
         unlock_irq_o <= unlock_status_reg && irq_enable_group4_reg[UNLOCK_EN_BIT];
      end
   end

   // Lock wait after any channel frequency write; restarts on every byte of a retune.
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         lock_cnt_reg  <= '0;
         retune_busy_o <= 1'b0;
      end else if (freq_wr) begin
         lock_cnt_reg  <= ($clog2(LOCK_CYCLES_P+1))'(LOCK_CYCLES_P - 1);
         retune_busy_o <= 1'b1;
      end else if (lock_cnt_reg != '0) begin
         lock_cnt_reg <= lock_cnt_reg - 1'b1;
      end else begin
         retune_busy_o <= 1'b0;
      end
   end

   // Receive holding byte and packet end indicator; a done pulse beats the clear of a new state command.
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         fifo_byte_reg          <= RESET_BYTE;
         fifo_last_reg          <= 1'b0;
         packet_end_indicator_o <= 1'b0;
      end else begin
         if (rx_byte_valid_i) begin
            fifo_byte_reg <= rx_byte_i;
            fifo_last_reg <= rx_last_i;
         end
         if (rx_packet_done_i) packet_end_indicator_o <= 1'b1;
         else if (state_cmd_wr) packet_end_indicator_o <= 1'b0;
      end
   end

   sequence s_tx_unlock;
      radio_state_o == RADIO_TX && unlock_rise && !state_cmd_wr;
   endsequence

   sequence s_rx_unlock;
      radio_state_o == RADIO_RX && unlock_rise && !state_cmd_wr;
   endsequence

   a_unlock_keeps_rx: assert property (@(posedge clock_i) disable iff (!rstn_i)
      s_rx_unlock |=> radio_state_o == RADIO_RX && unlock_status_reg) else $error("unlock left receive");

   a_unlock_stops_tx: assert property (@(posedge clock_i) disable iff (!rstn_i)
      s_tx_unlock |=> radio_state_o == RADIO_OFF) else $error("unlock did not stop transmit");

   a_unlock_irq_gate: assert property (@(posedge clock_i) disable iff (!rstn_i)
      unlock_rise ##1 irq_enable_group4_reg[UNLOCK_EN_BIT] |=> unlock_irq_o) else $error("unlock irq missing");

   a_lock_wait_span: assert property (@(posedge clock_i) disable iff (!rstn_i)
      freq_wr |=> retune_busy_o && lock_cnt_reg == ($clog2(LOCK_CYCLES_P+1))'(LOCK_CYCLES_P - 1))
      else $error("lock wait not started");

   a_preamble_store: assert property (@(posedge clock_i) disable iff (!rstn_i)
      wr_pulse_reg && wr_addr_reg == ADDR_TX_PRE_LEN |=> tx_preamble_length_o == $past(wr_data_reg))
      else $error("preamble length not stored");

   a_ramp_store: assert property (@(posedge clock_i) disable iff (!rstn_i)
      wr_pulse_reg && wr_addr_reg == ADDR_TX_OFF_ADJ |=> ramp_cfg_o.tx_off_adj == $past(wr_data_reg))
      else $error("ramp timing not stored");

   a_last_byte_gate: assert property (@(posedge clock_i) disable iff (!rstn_i)
      sclk_rise && bit_cnt_reg == BIT_ADDR_LAST && rx_sh_reg[6:0] == ADDR_RX_FIFO && fifo_last_reg &&
      !packet_end_indicator_o |=> tx_sh_reg == FIFO_BLANK) else $error("last byte read before packet end");

endmodule : freq_hop_channel_switch

// ===== fhop_pkg.sv
// Shared constants, register map and carrier types of the channel-switch control block.
package fhop_pkg;

   // Register offsets on the serial register port.
   localparam logic [6:0] ADDR_IRQ_EN4      = 7'h2D;
   localparam logic [6:0] ADDR_RX_ON_ADJ    = 7'h3F;
   localparam logic [6:0] ADDR_TX_PRE_LEN   = 7'h42;
   localparam logic [6:0] ADDR_CH_FREQ_LOW  = 7'h48;
   localparam logic [6:0] ADDR_CH_FREQ_MID  = 7'h49;
   localparam logic [6:0] ADDR_CH_FREQ_HIGH = 7'h4A;
   localparam logic [6:0] ADDR_TX_OFF_ADJ   = 7'h55;
   localparam logic [6:0] ADDR_RADIO_STATE  = 7'h6C;
   localparam logic [6:0] ADDR_DIV_GAIN     = 7'h6E;
   localparam logic [6:0] ADDR_RX_FIFO      = 7'h7C;

   // Field positions.
   localparam int UNLOCK_EN_BIT = 1;
   localparam int STATE_CMD_LSB = 0;
   localparam int STATE_RD_LSB  = 4;

   // Radio state command codes, also used to report the current state.
   localparam logic [3:0] CMD_RX_ON  = 4'h6;
   localparam logic [3:0] CMD_OFF    = 4'h8;
   localparam logic [3:0] CMD_TX_ON  = 4'h9;

   // Reset value, and the blank read value of the receive holding byte.
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [7:0] FIFO_BLANK = 8'h00;

   // Timing.
   localparam int CLK_PERIOD_NS = 10;
   localparam int LOCK_TIME_NS  = 100_000;
   localparam int LOCK_CYCLES   = (LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Serial frame layout: one address byte, then data bytes.
   localparam logic [3:0] BIT_ADDR_LAST = 4'h7;
   localparam logic [3:0] BIT_DATA_LAST = 4'hF;
   localparam logic [3:0] BIT_DATA_FIRST = 4'h8;

   typedef enum logic [1:0] {RADIO_OFF, RADIO_RX, RADIO_TX} radio_state_t;

   typedef struct packed {
      logic [7:0] gain;
      logic [7:0] rx_on_adj;
      logic [7:0] tx_off_adj;
   } ramp_cfg_t;

   typedef struct packed {
      logic [7:0] high;
      logic [7:0] mid;
      logic [7:0] low;
   } chan_freq_t;

endpackage : fhop_pkg

// ===== host_port_model.sv
// Host controller model that drives the serial register port in mode 0.
`timescale 1ns/1ps
module host_port_model #(
   parameter int HALF_P = 12
) (
   // Clock
   input  wire logic       clock_i,
   // Serial register port
   input  wire logic       sdo_i,
   input  wire logic       sdo_oen_i,
   output logic            sclk_o,
   output logic            csn_o,
   output logic            sdi_o,
   // Read results
   output logic            rd_valid_o,
   output logic [7:0]      rd_data_o
);
   initial begin
      sclk_o = 1'b0;
      csn_o = 1'b1;
      sdi_o = 1'b0;
      rd_valid_o = 1'b0;
      rd_data_o = 8'h00;
   end

   task automatic half_wait;
      repeat (HALF_P) @(posedge clock_i);
   endtask : half_wait

   // A released data line reads as the inverse of its level, so stale data never passes.
   task automatic shift_byte(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         sdi_o <= tx[i];
         half_wait();
         sclk_o <= 1'b1;
         rx[i] = sdo_oen_i ? ~sdo_i : sdo_i;
         half_wait();
         sclk_o <= 1'b0;
      end
   endtask : shift_byte

   // Address byte, then nbytes data bytes taken from the top of wdata; burst addresses increment.
   task automatic frame(input logic [6:0] addr, input logic wr, input logic [23:0] wdata, input int nbytes);
      logic [7:0] rx;
      csn_o <= 1'b0;
      half_wait();
      shift_byte({addr, wr}, rx);
      for (int b = 0; b < nbytes; b++) begin
         shift_byte(wdata[23-8*b -: 8], rx);
         if (!wr) begin
            rd_data_o <= rx;
            rd_valid_o <= 1'b1;
            @(posedge clock_i);
            rd_valid_o <= 1'b0;
         end
      end
      half_wait();
      csn_o <= 1'b1;
      sdi_o <= ~sdi_o;
      half_wait();
   endtask : frame
endmodule : host_port_model

// ===== tb.sv
// Self-checking bench of the channel switch control block.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin err_count++; \
   $display("Error %s expected %h seen %h", nm, ex, got); end end
module tb;
   import fhop_pkg::*;
   localparam int LOCK_P = 60;
   // Scaled bit period: a 255-byte preamble still outlasts one full scan of all hop channels.
   localparam int BIT_P = 2;
   localparam int HOP_CH = 25;
   localparam int DWELL_P = 36 * BIT_P + LOCK_P;
   localparam logic [23:0] BEACON_F = {8'h5A, 16'hA5C3};
   logic clock_i, rstn_i, sclk, csn, sdi, sdo, sdo_oen, pll_unlock, unlock_clear, unlock_irq, busy;
   logic rx_valid, rx_last, rx_done, pkt_end, rd_valid;
   logic [7:0] rx_byte, tx_pre, rd_data, v, e_mon, pat;
   logic [7:0] cv[5];
   logic [6:0] cfg_a[5];
   logic [23:0] f;
   chan_freq_t chan;
   radio_state_t rstate;
   ramp_cfg_t ramp;
   logic [7:0] exp_q[$];
   int err_count, checks_done;
   integer seed;

   freq_hop_channel_switch #(.LOCK_CYCLES_P(LOCK_P)) dut (.clock_i(clock_i), .rstn_i(rstn_i), .sclk_i(sclk),
      .csn_i(csn), .sdi_i(sdi), .sdo_o(sdo), .sdo_oen_o(sdo_oen), .pll_unlock_i(pll_unlock),
      .unlock_clear_i(unlock_clear), .unlock_irq_o(unlock_irq), .retune_busy_o(busy), .chan_freq_o(chan),
      .rx_byte_valid_i(rx_valid), .rx_byte_i(rx_byte), .rx_last_i(rx_last), .rx_packet_done_i(rx_done),
      .packet_end_indicator_o(pkt_end), .radio_state_o(rstate), .tx_preamble_length_o(tx_pre), .ramp_cfg_o(ramp));
   host_port_model host (.clock_i(clock_i), .sdo_i(sdo), .sdo_oen_i(sdo_oen), .sclk_o(sclk), .csn_o(csn),
      .sdi_o(sdi), .rd_valid_o(rd_valid), .rd_data_o(rd_data));

   initial begin
      clock_i = 1'b0;
      // The reference clock runs from time zero and never stops, so it leads every command.
      forever #5 clock_i = ~clock_i;
   end

   task automatic complete_run;
      if (err_count == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : complete_run

   task automatic reg_rd(input logic [6:0] a, input logic [23:0] e, input int n);
      for (int b = 0; b < n; b++) exp_q.push_back(e[23-8*b -: 8]);
      host.frame(a, 1'b0, 24'h0000_0000, n);
   endtask : reg_rd

   task automatic wr1(input logic [6:0] a, input logic [7:0] d);
      host.frame(a, 1'b1, {d, 16'h0000}, 1);
   endtask : wr1

   task automatic tick(input logic val);
      @(posedge clock_i);
      pll_unlock <= val;
      repeat (6) @(posedge clock_i);
   endtask : tick

   task automatic wait_idle;
      for (int n = 0; busy !== 1'b0; n++) begin
         if (n > LOCK_P + 10) begin
            err_count++;
            complete_run();
         end
         @(posedge clock_i);
      end
   endtask : wait_idle

   // Read results are compared in arrival order against the notes left by the driver.
   always @(posedge clock_i) begin
      if (rd_valid) begin
         e_mon = (exp_q.size() > 0) ? exp_q.pop_front() : ~rd_data;
         `CHK("read data", e_mon, rd_data)
      end
   end

   initial begin
      repeat (100_000) @(posedge clock_i);
      err_count++;
      complete_run();
   end

   initial begin
      seed = 23782;
      {rstn_i, pll_unlock, unlock_clear, rx_valid, rx_last, rx_done, rx_byte} = 14'h0000;
      cfg_a = '{ADDR_TX_PRE_LEN, ADDR_DIV_GAIN, ADDR_RX_ON_ADJ, ADDR_TX_OFF_ADJ, 7'h10};
      repeat (2) @(posedge clock_i);
      rstn_i <= 1'b1;
      repeat (3) @(posedge clock_i);
      reg_rd(ADDR_IRQ_EN4, {RESET_BYTE, 16'h0000}, 1);
      reg_rd(ADDR_RADIO_STATE, {CMD_OFF, CMD_OFF, 16'h0000}, 1);
      // The preamble length starts at its 255-byte ceiling; the last address is unmapped.
      for (int k = 0; k < 5; k++) begin
         cv[k] = (k == 0) ? 8'hFF : 8'($random(seed));
         wr1(cfg_a[k], cv[k]);
         reg_rd(cfg_a[k], {(k == 4) ? 8'h00 : cv[k], 16'h0000}, 1);
      end
      `CHK("preamble", cv[0], tx_pre)
      `CHK("ramp", {cv[1], cv[2], cv[3]}, ramp)
      wr1(ADDR_RADIO_STATE, {4'h0, CMD_TX_ON});
      `CHK("state tx", RADIO_TX, rstate)
      wr1(ADDR_RADIO_STATE, {4'h0, CMD_OFF});
      `CHK("state off", RADIO_OFF, rstate)
      f = 24'($random(seed));
      host.frame(ADDR_CH_FREQ_LOW, 1'b1, {f[7:0], f[15:8], f[23:16]}, 3);
      `CHK("busy", 1'b1, busy)
      `CHK("freq", f, chan)
      wait_idle();
      reg_rd(ADDR_CH_FREQ_LOW, {f[7:0], f[15:8], f[23:16]}, 3);
      wr1(ADDR_RADIO_STATE, {4'h0, CMD_RX_ON});
      wr1(ADDR_IRQ_EN4, 8'h02);
      tick(1'b1);
      `CHK("irq raised", 1'b1, unlock_irq)
      `CHK("rx kept", RADIO_RX, rstate)
      tick(1'b0);
      unlock_clear <= 1'b1;
      tick(1'b0);
      unlock_clear <= 1'b0;
      `CHK("irq cleared", 1'b0, unlock_irq)
      wr1(ADDR_IRQ_EN4, 8'h00);
      host.frame(ADDR_CH_FREQ_LOW, 1'b1, ~{f[7:0], f[15:8], f[23:16]}, 3);
      `CHK("freq masked", ~f, chan)
      tick(1'b1);
      `CHK("irq masked", 1'b0, unlock_irq)
      tick(1'b0);
      wait_idle();
      unlock_clear <= 1'b1;
      tick(1'b0);
      unlock_clear <= 1'b0;
      wr1(ADDR_IRQ_EN4, 8'h02);
      `CHK("irq after clear", 1'b0, unlock_irq)
      wr1(ADDR_RADIO_STATE, {4'h0, CMD_TX_ON});
      tick(1'b1);
      `CHK("tx forced off", RADIO_OFF, rstate)
      tick(1'b0);
      v = 8'($random(seed));
      rx_byte <= v;
      rx_last <= 1'b1;
      rx_valid <= 1'b1;
      @(posedge clock_i);
      rx_valid <= 1'b0;
      reg_rd(ADDR_RX_FIFO, {FIFO_BLANK, 16'h0000}, 1);
      rx_done <= 1'b1;
      @(posedge clock_i);
      rx_done <= 1'b0;
      @(posedge clock_i);
      `CHK("packet end", 1'b1, pkt_end)
      reg_rd(ADDR_RX_FIFO, {v, 16'h0000}, 1);
      wr1(ADDR_RADIO_STATE, {4'h0, CMD_OFF});
      `CHK("packet end clear", 1'b0, pkt_end)
      wr1(ADDR_RADIO_STATE, {4'h0, CMD_RX_ON});
      `CHK("preamble covers scan", 1'b1, (int'(tx_pre) * 8 * BIT_P) > (HOP_CH * DWELL_P))
      pat = 8'($random(seed)) | 8'h01;
      // Channel zero is the beacon channel; the numbered pattern sets every later hop.
      for (int c = 0; c <= HOP_CH; c++) begin
         f = BEACON_F + 24'(c * pat);
         host.frame(ADDR_CH_FREQ_LOW, 1'b1, {f[7:0], f[15:8], f[23:16]}, 3);
         `CHK("hop freq", f, chan)
         wait_idle();
         // No preamble is offered, so every visit ends after one dwell, far below the visit ceiling.
         repeat (DWELL_P) @(posedge clock_i);
      end
      `CHK("queue empty", 0, exp_q.size())
      complete_run();
   end
endmodule : tb
